// [serdes_tuning_consts.vh]
`ifndef SERDES_TUNING_CONSTS_VH
`define SERDES_TUNING_CONSTS_VH

// Management addressing
`define MGMT_DEV_ADDR 5'h1e
`define RX_TUNING_OFFSET 16'h0004
`define POL_TAP_OFFSET 16'h0005
`define UNMAPPED_READ 16'h0000

// Reset values
`define RX_TUNING_RESET 16'h1500
`define POL_TAP_RESET 16'h2000

// Receiver tuning register fields
`define ADC_TRACK_BIT 15
`define EQ_SEL_MSB 14
`define EQ_SEL_LSB 12
`define EQ_SEL_OFF 3'h7
`define CDR_ORDER_MSB 11
`define CDR_ORDER_LSB 10
`define CDR_ORDER_RSVD 2'h3
`define CDR_VOTE_MSB 9
`define CDR_VOTE_LSB 8
`define HF_PEAK_OFF_BIT 6
`define SHORT_CDR_BIT 5
`define CRF_MSB 4
`define CRF_LSB 0
`define CRF_RSVD_LO 5'h07
`define CRF_RSVD_HI 5'h0f

// Polarity and tap register fields
`define RX_INV_BIT 15
`define TX_INV_BIT 14
`define RSVD13_BIT 13
`define POST1_MSB 12
`define POST1_LSB 8
`define PRE_MSB 7
`define PRE_LSB 4
`define POST2_MSB 3
`define POST2_LSB 0

// Management frame timing, in management clock bits
`define MGMT_PREAMBLE_BITS 6'h20
`define MGMT_HDR_LAST 5'h0c
`define MGMT_TA_LAST 5'h01
`define MGMT_DATA_LAST 5'h0f

// Frame opcodes
`define OP_ADDRESS 2'h0
`define OP_WRITE 2'h1
`define OP_READ_INC 2'h2
`define OP_READ 2'h3

`endif

// [hs_serdes_tuning_regs.v]
// Notes on behaviour
// - Receiver tuning register at 0x0004, 16 bits, read/write, resets to 0x1500.
// - Bit 15 forces receive ADC into track mode; zero is normal.
// - Bits 14:12 pick precursor equalizer 1/9..13/9; 111 disables; reset 001.
// - Bits 11:10 pick CDR loop order; 01 at reset; 11 reserved.
// - Bits 9:8 pick CDR vote threshold 4, 8, 16 or 32; reset 01.
// - Bit 6 turns off high-frequency peaking for slow lines; reset zero.
// - Bit 5 enables short-channel CDR mode; resets to zero.
// - Bits 4:0 pick transmit cursor reduction; 00111..01111 reserved; reset zero.
// - Transmit swing code maps monotonically to 130..1400 mV amplitude.
// - Bit 15 of tap register complements received data; reset zero.
// - Bit 14 of tap register complements transmitted data; reset zero.
// - Tap register at 0x0005 resets to 0x2000; bit 13 read/write, resets one.
// - Bits 12:8 are post1 tap, sign-magnitude, 2.5% steps to 37.5%.
// - Bits 7:4 hold precursor tap weight, reset 0000.
// - Precursor tap is sign-magnitude, 2.5% steps up to 17.5%.
// - Bits 3:0 are post2 tap, sign-magnitude, 2.5% steps, reset zero.
`timescale 1ns/10ps
`include "serdes_tuning_consts.vh"
`default_nettype none

module hs_serdes_tuning_regs #(
	parameter [4:0] PORT_ADDR = 5'h00,
	parameter DATA_W = 20
) (
	input wire mclk,
	input wire arst_n,
	input wire mdc,
	input wire mdio_in,
	output reg mdio_out,
	output reg mdio_oe,
	input wire [3:0] tx_swing_level,
	input wire [DATA_W-1:0] rx_line_data,
	input wire [DATA_W-1:0] tx_data,
	output reg [DATA_W-1:0] rx_data,
	output reg [DATA_W-1:0] tx_line_pos,
	output reg [DATA_W-1:0] tx_line_neg,
	output wire adc_track_force,
	output wire [2:0] rx_precursor_eq_sel,
	output reg rx_eq_off,
	output wire [1:0] cdr_loop_order_sel,
	output reg cdr_order_rsvd,
	output wire [1:0] cdr_vote_threshold,
	output reg [5:0] cdr_vote_count,
	output wire hf_peaking_off,
	output wire short_channel_cdr,
	output wire [4:0] tx_cursor_reduction,
	output reg crf_rsvd,
	output reg [10:0] tx_swing_mv,
	output wire rx_pair_invert,
	output wire tx_pair_invert,
	output wire [4:0] tx_post1_tap,
	output wire [3:0] tx_pre_tap,
	output wire [3:0] tx_post2_tap,
	output reg signed [4:0] post1_steps,
	output reg signed [3:0] pre_steps,
	output reg signed [3:0] post2_steps
);

	localparam [1:0] ST_PRE = 2'h0;
	localparam [1:0] ST_HDR = 2'h1;
	localparam [1:0] ST_TA = 2'h2;
	localparam [1:0] ST_DAT = 2'h3;

	// Amplitude in mV for each swing code, rising with the code
	function [10:0] swing_mv;
		input [3:0] code;
		begin
			case (code)
				4'h0: swing_mv = 11'd130;
				4'h1: swing_mv = 11'd220;
				4'h2: swing_mv = 11'd300;
				4'h3: swing_mv = 11'd390;
				4'h4: swing_mv = 11'd480;
				4'h5: swing_mv = 11'd570;
				4'h6: swing_mv = 11'd660;
				4'h7: swing_mv = 11'd750;
				4'h8: swing_mv = 11'd830;
				4'h9: swing_mv = 11'd930;
				4'ha: swing_mv = 11'd1020;
				4'hb: swing_mv = 11'd1110;
				4'hc: swing_mv = 11'd1180;
				4'hd: swing_mv = 11'd1270;
				4'he: swing_mv = 11'd1340;
				default: swing_mv = 11'd1400;
			endcase
		end
	endfunction

	// Sign-magnitude tap code to signed count of 2.5% steps, 4-bit form
	function signed [3:0] sm4_to_tc;
		input [3:0] code;
		begin
			if (code[3]) begin
				sm4_to_tc = -$signed({1'b0, code[2:0]});
			end else begin
				sm4_to_tc = $signed({1'b0, code[2:0]});
			end
		end
	endfunction

	// Sign-magnitude tap code to signed count of 2.5% steps, 5-bit form
	function signed [4:0] sm5_to_tc;
		input [4:0] code;
		begin
			if (code[4]) begin
				sm5_to_tc = -$signed({1'b0, code[3:0]});
			end else begin
				sm5_to_tc = $signed({1'b0, code[3:0]});
			end
		end
	endfunction

	// One-hot register select: bit 0 receiver tuning, bit 1 polarity and tap
	function [1:0] reg_hit;
		input [15:0] addr;
		begin
			reg_hit = {(addr == `POL_TAP_OFFSET), (addr == `RX_TUNING_OFFSET)};
		end
	endfunction

	// Register read decode by management address
	function [15:0] read_mux;
		input [15:0] addr;
		input [15:0] rx_tuning;
		input [15:0] pol_tap;
		begin
			case (addr)
				`RX_TUNING_OFFSET: read_mux = rx_tuning;
				`POL_TAP_OFFSET: read_mux = pol_tap;
				default: read_mux = `UNMAPPED_READ;
			endcase
		end
	endfunction

	reg mdc_s1_reg;
	reg mdc_s2_reg;
	reg mdc_d_reg;
	reg mdio_s1_reg;
	reg mdio_s2_reg;
	reg [1:0] state_reg;
	reg [5:0] pre_cnt_reg;
	reg [4:0] bit_cnt_reg;
	reg [12:0] hdr_reg;
	reg [15:0] shift_reg;
	reg [15:0] addr_reg;
	reg [1:0] op_reg;
	reg match_reg;
	reg [15:0] hs_rx_tuning_ctrl_reg;
	reg [15:0] hs_polarity_tap_ctrl_reg;
	wire mdc_rise;
	wire bit_in;
	wire [12:0] hdr_next;
	wire hdr_match;
	wire [15:0] data_next;
	wire [1:0] addr_hit;

	// Two-stage synchronisers for the management pins
	// Data resets high so the idle pull-up level shows no false start bit
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mdc_s1_reg <= 1'b0;
			mdc_s2_reg <= 1'b0;
			mdc_d_reg <= 1'b0;
			mdio_s1_reg <= 1'b1;
			mdio_s2_reg <= 1'b1;
		end else begin
			mdc_s1_reg <= mdc;
			mdc_s2_reg <= mdc_s1_reg;
			mdc_d_reg <= mdc_s2_reg;
			mdio_s1_reg <= mdio_in;
			mdio_s2_reg <= mdio_s1_reg;
		end
	end

	// Bits are taken on the rising management clock edge
	// The mdc period must span several mclk periods, or edges are lost
	assign mdc_rise = mdc_s2_reg & ~mdc_d_reg;
	assign bit_in = mdio_s2_reg;
	assign hdr_next = {hdr_reg[11:0], bit_in};
	assign data_next = {shift_reg[14:0], bit_in};
	// Header: second start bit, opcode, port, device
	assign hdr_match = (hdr_next[12] == 1'b0) && (hdr_next[9:5] == PORT_ADDR) &&
		(hdr_next[4:0] == `MGMT_DEV_ADDR);
	// Pointer decode for the write strobe
	assign addr_hit = reg_hit(addr_reg);

	// Frame sequencer, address pointer and register writes
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_PRE;
			pre_cnt_reg <= 6'h00;
			bit_cnt_reg <= 5'h00;
			hdr_reg <= 13'h0000;
			shift_reg <= 16'h0000;
			addr_reg <= 16'h0000;
			op_reg <= `OP_ADDRESS;
			match_reg <= 1'b0;
			mdio_out <= 1'b0;
			mdio_oe <= 1'b0;
			hs_rx_tuning_ctrl_reg <= `RX_TUNING_RESET;
			hs_polarity_tap_ctrl_reg <= `POL_TAP_RESET;
		end else if (mdc_rise) begin
			case (state_reg)
				ST_PRE: begin
					mdio_oe <= 1'b0;
					if (bit_in) begin
						// Saturate so a longer preamble is still accepted
						if (pre_cnt_reg != `MGMT_PREAMBLE_BITS) begin
							pre_cnt_reg <= pre_cnt_reg + 6'h01;
						end
					end else if (pre_cnt_reg == `MGMT_PREAMBLE_BITS) begin
						// First start bit ends the preamble
						state_reg <= ST_HDR;
						bit_cnt_reg <= 5'h00;
					end else begin
						pre_cnt_reg <= 6'h00;
					end
				end
				ST_HDR: begin
					// Header bits shift in; the last one settles opcode, port and device
					hdr_reg <= hdr_next;
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
					if (bit_cnt_reg == `MGMT_HDR_LAST) begin
						op_reg <= hdr_next[11:10];
						match_reg <= hdr_match;
						state_reg <= ST_TA;
						bit_cnt_reg <= 5'h00;
						// Capture read data before turnaround so it holds for the data phase
						shift_reg <= read_mux(addr_reg, hs_rx_tuning_ctrl_reg,
							hs_polarity_tap_ctrl_reg);
					end
				end
				ST_TA: begin
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
					if (bit_cnt_reg == 5'h00) begin
						// Drive the low turnaround bit on reads
						mdio_oe <= match_reg & op_reg[1];
						mdio_out <= 1'b0;
					end
					if (bit_cnt_reg == `MGMT_TA_LAST) begin
						state_reg <= ST_DAT;
						bit_cnt_reg <= 5'h00;
						mdio_out <= shift_reg[15];
					end
				end
				ST_DAT: begin
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
					// Reads shift out one bit per rise; writes shift in
					if (op_reg[1]) begin
						shift_reg <= {shift_reg[14:0], 1'b0};
						mdio_out <= shift_reg[14];
					end else begin
						shift_reg <= data_next;
					end
					if (bit_cnt_reg == `MGMT_DATA_LAST) begin
						state_reg <= ST_PRE;
						pre_cnt_reg <= 6'h00;
						// Release the line at the last rise so the host may start anew
						mdio_oe <= 1'b0;
						if (match_reg) begin
							case (op_reg)
								`OP_ADDRESS: addr_reg <= data_next;
								`OP_WRITE: begin
									// Whole register updates at once
									if (addr_hit[0]) begin
										hs_rx_tuning_ctrl_reg <= data_next;
									end
									if (addr_hit[1]) begin
										hs_polarity_tap_ctrl_reg <= data_next;
									end
								end
								`OP_READ_INC: addr_reg <= addr_reg + 16'h0001;
								default: addr_reg <= addr_reg;
							endcase
						end
					end
				end
				default: state_reg <= ST_PRE;
			endcase
		end
	end

	// Field slices of the receiver tuning register
	assign adc_track_force = hs_rx_tuning_ctrl_reg[`ADC_TRACK_BIT];
	assign rx_precursor_eq_sel = hs_rx_tuning_ctrl_reg[`EQ_SEL_MSB:`EQ_SEL_LSB];
	assign cdr_loop_order_sel = hs_rx_tuning_ctrl_reg[`CDR_ORDER_MSB:`CDR_ORDER_LSB];
	assign cdr_vote_threshold = hs_rx_tuning_ctrl_reg[`CDR_VOTE_MSB:`CDR_VOTE_LSB];
	assign hf_peaking_off = hs_rx_tuning_ctrl_reg[`HF_PEAK_OFF_BIT];
	assign short_channel_cdr = hs_rx_tuning_ctrl_reg[`SHORT_CDR_BIT];
	assign tx_cursor_reduction = hs_rx_tuning_ctrl_reg[`CRF_MSB:`CRF_LSB];

	// Field slices of the polarity and tap register
	assign rx_pair_invert = hs_polarity_tap_ctrl_reg[`RX_INV_BIT];
	assign tx_pair_invert = hs_polarity_tap_ctrl_reg[`TX_INV_BIT];
	assign tx_post1_tap = hs_polarity_tap_ctrl_reg[`POST1_MSB:`POST1_LSB];
	assign tx_pre_tap = hs_polarity_tap_ctrl_reg[`PRE_MSB:`PRE_LSB];
	assign tx_post2_tap = hs_polarity_tap_ctrl_reg[`POST2_MSB:`POST2_LSB];

	// Decoded settings, one clock behind the registers and the swing code input
	// Registering them keeps the table lookups off the register outputs
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_eq_off <= 1'b0;
			cdr_order_rsvd <= 1'b0;
			cdr_vote_count <= 6'h00;
			crf_rsvd <= 1'b0;
			tx_swing_mv <= 11'h000;
			post1_steps <= 5'sh00;
			pre_steps <= 4'sh0;
			post2_steps <= 4'sh0;
		end else begin
			rx_eq_off <= (rx_precursor_eq_sel == `EQ_SEL_OFF);
			cdr_order_rsvd <= (cdr_loop_order_sel == `CDR_ORDER_RSVD);
			cdr_vote_count <= 6'h04 << cdr_vote_threshold;
			crf_rsvd <= (tx_cursor_reduction >= `CRF_RSVD_LO) &&
				(tx_cursor_reduction <= `CRF_RSVD_HI);
			tx_swing_mv <= swing_mv(tx_swing_level);
			post1_steps <= sm5_to_tc(tx_post1_tap);
			pre_steps <= sm4_to_tc(tx_pre_tap);
			post2_steps <= sm4_to_tc(tx_post2_tap);
		end
	end

	// Lane polarity swap on the receive and transmit paths
	// A swap is a plain inversion of every lane bit
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_data <= {DATA_W{1'b0}};
			tx_line_pos <= {DATA_W{1'b0}};
			tx_line_neg <= {DATA_W{1'b1}};
		end else begin
			rx_data <= rx_line_data ^ {DATA_W{rx_pair_invert}};
			tx_line_pos <= tx_data ^ {DATA_W{tx_pair_invert}};
			tx_line_neg <= ~(tx_data ^ {DATA_W{tx_pair_invert}});
		end
	end

endmodule // hs_serdes_tuning_regs

`default_nettype wire

// [serdes_tuning_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module serdes_tuning_checker #(
	parameter DATA_W = 20
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	input wire logic [3:0] tx_swing_level,
	input wire logic [DATA_W-1:0] rx_line_data,
	input wire logic [DATA_W-1:0] tx_data,
	input wire logic [DATA_W-1:0] rx_data,
	input wire logic [DATA_W-1:0] tx_line_pos,
	input wire logic [DATA_W-1:0] tx_line_neg,
	input wire logic [2:0] rx_precursor_eq_sel,
	input wire logic rx_eq_off,
	input wire logic [1:0] cdr_loop_order_sel,
	input wire logic cdr_order_rsvd,
	input wire logic [1:0] cdr_vote_threshold,
	input wire logic [5:0] cdr_vote_count,
	input wire logic [4:0] tx_cursor_reduction,
	input wire logic crf_rsvd,
	input wire logic [10:0] tx_swing_mv,
	input wire logic rx_pair_invert,
	input wire logic tx_pair_invert,
	input wire logic [4:0] tx_post1_tap,
	input wire logic [3:0] tx_pre_tap,
	input wire logic [3:0] tx_post2_tap,
	input wire logic signed [4:0] post1_steps,
	input wire logic signed [3:0] pre_steps,
	input wire logic signed [3:0] post2_steps
);
	// Amplitude in mV per swing code, 12 bits per entry, code 0 lowest
	localparam logic [191:0] SWING_TBL = {48'h578_53c_4f6_49c, 48'h456_3fc_3a2_33e,
		48'h2ee_294_23a_1e0, 48'h186_12c_0dc_082};
	// Vote count per threshold code, 6 bits per entry, code 0 lowest
	localparam logic [23:0] VOTE_TBL = {6'd32, 6'd16, 6'd8, 6'd4};
	// Signed step count from a sign bit and a magnitude
	function automatic logic signed [5:0] sm(input logic s, input logic [3:0] m);
		sm = s ? -$signed({2'b00, m}) : $signed({2'b00, m});
	endfunction
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// Decodes lag their register by one cycle, so the cycle before must be out of reset
	sequence live_s;
		$past(arst_n);
	endsequence
	sequence drive_s;
		mdio_oe [*8];
	endsequence
	rx_invert_a: assert property (live_s |-> rx_data == ($past(rx_line_data) ^ {DATA_W{$past(rx_pair_invert)}}))
		else $error("received data polarity wrong");
	tx_invert_a: assert property (live_s |-> tx_line_pos == ($past(tx_data) ^ {DATA_W{$past(tx_pair_invert)}}) && tx_line_neg == ~tx_line_pos)
		else $error("transmit pair polarity wrong");
	eq_off_a: assert property (live_s |-> rx_eq_off == ($past(rx_precursor_eq_sel) == 3'h7))
		else $error("equalizer disable decode wrong");
	cdr_order_a: assert property (live_s |-> cdr_order_rsvd == ($past(cdr_loop_order_sel) == 2'h3))
		else $error("loop order reserved decode wrong");
	vote_count_a: assert property (live_s |-> cdr_vote_count == VOTE_TBL[6 * $past(cdr_vote_threshold) +: 6])
		else $error("vote threshold decode wrong");
	crf_reserved_a: assert property (live_s |-> crf_rsvd == ($past(tx_cursor_reduction) >= 5'h07 && $past(tx_cursor_reduction) <= 5'h0f))
		else $error("cursor reduction reserved decode wrong");
	swing_mv_a: assert property (live_s |-> tx_swing_mv == SWING_TBL[12 * $past(tx_swing_level) +: 11])
		else $error("swing amplitude decode wrong");
	post1_steps_a: assert property (live_s |-> post1_steps == sm($past(tx_post1_tap[4]), $past(tx_post1_tap[3:0])))
		else $error("post1 tap decode wrong");
	pre_steps_a: assert property (live_s |-> pre_steps == sm($past(tx_pre_tap[3]), {1'b0, $past(tx_pre_tap[2:0])}))
		else $error("precursor tap decode wrong");
	post2_steps_a: assert property (live_s |-> post2_steps == sm($past(tx_post2_tap[3]), {1'b0, $past(tx_post2_tap[2:0])}))
		else $error("post2 tap decode wrong");
	read_drive_a: assert property ($rose(mdio_oe) |-> !mdio_out ##0 drive_s)
		else $error("read turnaround drive wrong");
endmodule // serdes_tuning_checker
`default_nettype wire

// [mgmt_station.sv]
`timescale 1ns/10ps
`default_nettype none
module mgmt_station (
	input wire logic mclk,
	input wire logic mdio_wire,
	output logic mdc,
	output logic mdio_drv,
	output logic mdio_en
);
	// Clock stands low and the line is released between frames
	initial begin
		mdc = 1'b0;
		mdio_drv = 1'b1;
		mdio_en = 1'b0;
	end
	// Whole frame with its own preamble; bits change while mdc is low, read bits taken at rise
	task automatic frame(input logic [1:0] op, input logic [4:0] port, input logic [15:0] data,
		output logic [15:0] rd);
		logic [63:0] bits;
		bits = {32'hffff_ffff, 2'h0, op, port, 5'h1e, 2'h2, data};
		// Start just after an edge, one cycle clear of the last frame's release
		@(posedge mclk);
		#1;
		for (int i = 63; i >= 0; i--) begin
			mdio_en = !(op[1] && i < 18); // Host lets go of turnaround and data on reads
			mdio_drv = bits[i];
			repeat (6) @(posedge mclk);
			#1 mdc = 1'b1;
			if (i < 16) rd[i] = mdio_wire;
			repeat (6) @(posedge mclk);
			#1 mdc = 1'b0;
		end
		mdio_en = 1'b0;
	endtask
endmodule // mgmt_station
`default_nettype wire

// [hs_serdes_tuning_regs_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module hs_serdes_tuning_regs_tb;
	localparam logic [4:0] PADDR = 5'h03;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] tx_swing_level = 4'h0;
	logic [19:0] rx_line_data = 20'h00000;
	logic [19:0] tx_data = 20'h0f0f0;
	logic [15:0] rd;
	logic [15:0] v4 [4] = '{16'hffff, 16'h0000, 16'ha6a7, 16'h6b4f};
	logic [15:0] v5 [4] = '{16'h9f9a, 16'hffff, 16'h4ef7, 16'h0000};
	wire logic mdc, mdio_drv, mdio_en, mdio_wire, mdio_out, mdio_oe;
	wire logic adc_track_force, hf_peaking_off, short_channel_cdr, rx_pair_invert, tx_pair_invert;
	wire logic [2:0] rx_precursor_eq_sel;
	wire logic [1:0] cdr_loop_order_sel, cdr_vote_threshold;
	wire logic [4:0] tx_cursor_reduction, tx_post1_tap;
	wire logic [3:0] tx_pre_tap, tx_post2_tap;
	int bad_count = 0;
	int comparisons = 0;
	always #4 mclk = ~mclk;
	// Pulled-up line: the block, else the host, else high
	assign mdio_wire = mdio_oe ? mdio_out : (mdio_en ? mdio_drv : 1'b1);
	// Lane data and swing code move every cycle
	always @(posedge mclk) begin
		#1;
		rx_line_data = rx_line_data + 20'h00001;
		tx_data = tx_data + 20'h00003;
		tx_swing_level = tx_swing_level + 4'h1;
	end
	mgmt_station host (.mclk(mclk), .mdio_wire(mdio_wire), .mdc(mdc), .mdio_drv(mdio_drv),
		.mdio_en(mdio_en));
	hs_serdes_tuning_regs #(.PORT_ADDR(PADDR), .DATA_W(20)) dut (.mclk(mclk), .arst_n(arst_n),
		.mdc(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
		.tx_swing_level(tx_swing_level), .rx_line_data(rx_line_data), .tx_data(tx_data),
		.rx_data(), .tx_line_pos(), .tx_line_neg(), .adc_track_force(adc_track_force),
		.rx_precursor_eq_sel(rx_precursor_eq_sel), .rx_eq_off(),
		.cdr_loop_order_sel(cdr_loop_order_sel), .cdr_order_rsvd(),
		.cdr_vote_threshold(cdr_vote_threshold), .cdr_vote_count(),
		.hf_peaking_off(hf_peaking_off), .short_channel_cdr(short_channel_cdr),
		.tx_cursor_reduction(tx_cursor_reduction), .crf_rsvd(), .tx_swing_mv(),
		.rx_pair_invert(rx_pair_invert), .tx_pair_invert(tx_pair_invert),
		.tx_post1_tap(tx_post1_tap), .tx_pre_tap(tx_pre_tap), .tx_post2_tap(tx_post2_tap),
		.post1_steps(), .pre_steps(), .post2_steps());
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// Field pins must follow the register bits they are cut from
	task automatic fields(input logic [15:0] e4, input logic [15:0] e5);
		check(16'(adc_track_force), 16'(e4[15]));
		check(16'(rx_precursor_eq_sel), 16'(e4[14:12]));
		check(16'(cdr_loop_order_sel), 16'(e4[11:10]));
		check(16'(cdr_vote_threshold), 16'(e4[9:8]));
		check(16'(hf_peaking_off), 16'(e4[6]));
		check(16'(short_channel_cdr), 16'(e4[5]));
		check(16'(tx_cursor_reduction), 16'(e4[4:0]));
		check(16'(rx_pair_invert), 16'(e5[15]));
		check(16'(tx_pair_invert), 16'(e5[14]));
		check(16'(tx_post1_tap), 16'(e5[12:8]));
		check(16'(tx_pre_tap), 16'(e5[7:4]));
		check(16'(tx_post2_tap), 16'(e5[3:0]));
	endtask
	// Point at a register, then write it
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		host.frame(2'h0, PADDR, a, rd);
		host.frame(2'h1, PADDR, d, rd);
	endtask
	// Point at a register, read it and compare
	task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
		host.frame(2'h0, PADDR, a, rd);
		host.frame(2'h3, PADDR, 16'h0000, rd);
		check(rd, exp);
	endtask
	task automatic results();
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Cut a hang short; the run needs about 51 frames of 770 cycles
	initial begin
		repeat (60000) @(posedge mclk);
		bad_count++;
		results();
	end
	initial begin
		repeat (10) @(posedge mclk);
		#1 arst_n = 1'b1;
		repeat (4) @(posedge mclk);
		fields(16'h1500, 16'h2000);
		rdc(16'h0004, 16'h1500);
		rdc(16'h0005, 16'h2000);
		for (int i = 0; i < 4; i++) begin
			wr(16'h0004, v4[i]);
			wr(16'h0005, v5[i]);
			rdc(16'h0004, v4[i]);
			rdc(16'h0005, v5[i]);
			fields(v4[i], v5[i]);
		end
		// A frame for another port leaves the register alone
		host.frame(2'h1, 5'h04, 16'h1234, rd);
		host.frame(2'h3, PADDR, 16'h0000, rd);
		check(rd, v5[3]);
		// Read with increment steps on to the next register
		host.frame(2'h0, PADDR, 16'h0004, rd);
		host.frame(2'h2, PADDR, 16'h0000, rd);
		check(rd, v4[3]);
		host.frame(2'h3, PADDR, 16'h0000, rd);
		check(rd, v5[3]);
		wr(16'h0006, 16'hffff);
		rdc(16'h0006, 16'h0000);
		rdc(16'h0004, v4[3]);
		// Reset in mid-run brings both registers back to their reset values
		@(posedge mclk);
		#1 arst_n = 1'b0;
		repeat (2) @(posedge mclk);
		#1 arst_n = 1'b1;
		repeat (4) @(posedge mclk);
		fields(16'h1500, 16'h2000);
		rdc(16'h0004, 16'h1500);
		rdc(16'h0005, 16'h2000);
		results();
	end
endmodule // hs_serdes_tuning_regs_tb
bind hs_serdes_tuning_regs serdes_tuning_checker #(.DATA_W(DATA_W)) chk (.*);
`default_nettype wire
